/* hw/dao_top.sv */
`timescale 1ns/10ps
`default_nettype none
module dao_top #(
  parameter int unsigned FIFO_DEPTH = dao_pkg::FIFO_DEPTH_DEF
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic conversion_clock,
  input wire logic chip_powerdown_n,
  input wire logic sample_format_select,
  input wire logic sync_clock_out_enable_n,
  input wire logic ch0_output_enable,
  input wire logic ch1_output_enable_n,
  input wire logic sleep_ctrl_hi,
  input wire logic sleep_ctrl_lo,
  input wire logic cm_buffer_bias_hi,
  input wire logic cm_buffer_bias_lo,
  input wire logic [dao_pkg::STAGE_W-1:0] ch0_stage_code,
  input wire logic [dao_pkg::STAGE_W-1:0] ch1_stage_code,
  input wire logic [dao_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [dao_pkg::SAMPLE_W-1:0] ch0_sample,
  output logic ch0_sample_oe,
  output logic ch0_overrange_flag,
  output logic [dao_pkg::SAMPLE_W-1:0] ch1_sample,
  output logic ch1_sample_oe,
  output logic ch1_overrange_flag,
  output logic sync_clock_out,
  output logic sync_clock_out_oe,
  output logic [1:0] cm_buffer_bias,
  output logic cm_buffer_on
);
  import dao_pkg::*;
  localparam int unsigned CW = SAMPLE_W + 1;
  localparam int unsigned WORD_W = 2 * CW;
  localparam int unsigned LVL_W = $clog2(FIFO_DEPTH) + 1;

  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 128 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("dao_top fifo depth must be a power of two from 2 to 128");
  end

  // ==========================================
  // pin synchronisers
  logic conv_s;
  logic pd_n_s;
  logic fmt_s;
  logic clkoe_n_s;
  logic oe0_s;
  logic oe1_n_s;
  logic [1:0] slp_s;
  logic [1:0] bias_s;
  logic pd;

  dao_sync #(
    .W(10)
  ) u_pins (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in({conversion_clock, chip_powerdown_n, sample_format_select,
               sync_clock_out_enable_n, ch0_output_enable, ch1_output_enable_n,
               sleep_ctrl_hi, sleep_ctrl_lo, cm_buffer_bias_hi, cm_buffer_bias_lo}),
    .sync_out({conv_s, pd_n_s, fmt_s, clkoe_n_s, oe0_s, oe1_n_s, slp_s, bias_s})
  );

  assign pd = ~pd_n_s;

  // ==========================================
  // conversion clock edges
  logic conv_prev_q;
  logic conv_rise;
  logic conv_fall;

  assign conv_rise = conv_s & ~conv_prev_q;
  assign conv_fall = ~conv_s & conv_prev_q;

  // ==========================================
  // chip mode and wake-up counters
  dao_mode_type mode_q;
  dao_mode_type mode_d;
  logic [WAKE_CNT_W-1:0] wake_q;
  logic [WAKE_CNT_W-1:0] wake_d;
  logic [SLEEP_CNT_W-1:0] chw_q [2];
  logic [SLEEP_CNT_W-1:0] chw_d [2];
  logic [1:0] awake;
  logic [1:0] ch_rdy;
  logic [1:0] ch_ok;
  logic standby;

  // code 01 keeps channel 0 alone awake
  assign awake[0] = (slp_s == SLEEP_NONE) || (slp_s == SLEEP_CH0_ONLY);
  assign awake[1] = (slp_s == SLEEP_NONE) || (slp_s == SLEEP_CH1_ONLY);
  assign standby = (slp_s == SLEEP_BOTH);

  always_comb
  begin
    mode_d = mode_q;
    wake_d = wake_q;
    case (mode_q)
      MODE_DOWN:
      begin
        wake_d = '0;
        if (!pd)
          mode_d = MODE_WAKE;
      end
      MODE_WAKE:
      begin
        if (conv_rise)
        begin
          if (wake_q == WAKE_PD_CYC - 1'b1)
            mode_d = MODE_RUN;
          else
            wake_d = wake_q + 1'b1;
        end
      end
      MODE_RUN:
        wake_d = wake_q;
      default:
        mode_d = MODE_DOWN;
    endcase
    if (pd)
      mode_d = MODE_DOWN;
    for (int c = 0; c < 2; c++)
    begin
      chw_d[c] = chw_q[c];
      if (!awake[c] || mode_q == MODE_DOWN)
        chw_d[c] = '0;
      else if (conv_rise && chw_q[c] != WAKE_SLEEP_CYC)
        chw_d[c] = chw_q[c] + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_q <= MODE_DOWN;
      wake_q <= '0;
      chw_q[0] <= '0;
      chw_q[1] <= '0;
      conv_prev_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      wake_q <= wake_d;
      chw_q <= chw_d;
      conv_prev_q <= conv_s;
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_ch
    assign ch_rdy[c] = (chw_q[c] == WAKE_SLEEP_CYC);
    assign ch_ok[c] = (mode_q == MODE_RUN) & awake[c] & ch_rdy[c];
  end

  // ==========================================
  // error correction and capture into the fifo
  function automatic logic [CW-1:0] correct(input logic [STAGE_W-1:0] s);
    logic [STAGE_W-1:0] t;
    t = s - STAGE_OFFSET;
    if (s < STAGE_OFFSET)
      correct = {1'b1, {SAMPLE_W{1'b0}}};
    else if (t > {1'b0, CODE_MAX})
      correct = {1'b1, CODE_MAX};
    else
      correct = {1'b0, t[SAMPLE_W-1:0]};
  endfunction : correct

  logic [WORD_W-1:0] cap_word;
  logic [WORD_W-1:0] word;
  logic push_req;
  logic in_ready;
  logic out_valid;
  logic pop;
  logic hold_q;
  logic [LVL_W-1:0] level;

  assign cap_word = {correct(ch1_stage_code), correct(ch0_stage_code)};
  assign push_req = conv_rise & (mode_q != MODE_DOWN);
  assign pop = conv_rise & out_valid & ~hold_q & ~pd;

  dao_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clear(pd),
    .in_valid(push_req),
    .in_ready(in_ready),
    .in_data(cap_word),
    .out_valid(out_valid),
    .out_ready(pop),
    .out_data(word),
    .level(level)
  );

  // ==========================================
  // output stage
  logic [SAMPLE_W-1:0] smp_q [2];
  logic [SAMPLE_W-1:0] smp_d [2];
  logic [1:0] ovr_q;
  logic [1:0] ovr_d;
  logic [1:0] oe_q;
  logic [1:0] oe_d;
  logic sclk_q;
  logic sclk_d;
  logic sclk_oe_q;
  logic [1:0] bias_q;
  logic cm_on_q;
  logic [CW-1:0] cw;

  always_comb
  begin
    cw = '0;
    for (int c = 0; c < 2; c++)
    begin
      smp_d[c] = smp_q[c];
      ovr_d[c] = ovr_q[c];
      if (pop)
      begin
        cw = word[c*CW +: CW];
        smp_d[c] = '0;
        ovr_d[c] = 1'b0;
        if (ch_ok[c])
        begin
          smp_d[c] = {cw[SAMPLE_W-1] ^ (fmt_s == FMT_TWOS_COMP), cw[SAMPLE_W-2:0]};
          ovr_d[c] = cw[SAMPLE_W];
        end
      end
      if (pd)
      begin
        smp_d[c] = '0;
        ovr_d[c] = 1'b0;
      end
    end
    oe_d[0] = oe0_s;
    oe_d[1] = ~oe1_n_s;
    sclk_d = sclk_q;
    if (conv_rise)
      sclk_d = 1'b0;
    else if (conv_fall)
      sclk_d = 1'b1;
    if (pd)
      sclk_d = 1'b0;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      smp_q[0] <= '0;
      smp_q[1] <= '0;
      ovr_q <= '0;
      oe_q <= '0;
      sclk_q <= 1'b0;
      sclk_oe_q <= 1'b0;
      bias_q <= CM_BIAS_OFF;
      cm_on_q <= 1'b0;
    end
    else
    begin
      smp_q <= smp_d;
      ovr_q <= ovr_d;
      oe_q <= oe_d;
      sclk_q <= sclk_d;
      sclk_oe_q <= ~clkoe_n_s;
      bias_q <= pd ? CM_BIAS_OFF : bias_s;
      cm_on_q <= ~pd & (bias_s != CM_BIAS_OFF);
    end
  end

  assign ch0_sample = smp_q[0];
  assign ch1_sample = smp_q[1];
  assign ch0_overrange_flag = ovr_q[0];
  assign ch1_overrange_flag = ovr_q[1];
  assign ch0_sample_oe = oe_q[0];
  assign ch1_sample_oe = oe_q[1];
  assign sync_clock_out = sclk_q;
  assign sync_clock_out_oe = sclk_oe_q;
  assign cm_buffer_bias = bias_q;
  assign cm_buffer_on = cm_on_q;

  // ==========================================
  // wishbone slave
  logic hold_d;
  logic [DROP_W-1:0] drop_q;
  logic [DROP_W-1:0] drop_d;
  logic [WORD_W-1:0] last_q;
  logic [WORD_W-1:0] last_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic req;

  assign req = wb_cyc_i & wb_stb_i & ~ack_q;

  always_comb
  begin
    ack_d = req;
    dat_d = '0;
    hold_d = hold_q;
    drop_d = drop_q;
    last_d = last_q;
    if (push_req && !in_ready)
      drop_d = drop_q + 1'b1;
    if (push_req && in_ready)
      last_d = cap_word;
    if (req && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0])
      hold_d = wb_dat_i[CTRL_HOLD_BIT];
    if (req && !wb_we_i)
    begin
      case (wb_adr_i)
        REG_CTRL: dat_d = {31'h0, hold_q};
        REG_STATUS: dat_d = {16'h0, 8'(level), 1'b0, mode_q, standby, ch_ok, pd_n_s};
        REG_DROPS: dat_d = {16'h0, drop_q};
        REG_LAST: dat_d = {10'h0, last_q};
        default: dat_d = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_q <= 1'b0;
      dat_q <= '0;
      hold_q <= CTRL_HOLD_RESET;
      drop_q <= '0;
      last_q <= '0;
    end
    else
    begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      hold_q <= hold_d;
      drop_q <= drop_d;
      last_q <= last_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ==========================================
  // checks
  chk_pd_outputs_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    pd && $past(pd) |-> smp_q[0] == '0 && smp_q[1] == '0 && ovr_q == '0 && !sclk_q && !cm_on_q)
    else $error("outputs not zero in power-down");

  chk_clk_out_enable: assert property (@(posedge core_clk) disable iff (!reset_n)
    reset_n |=> sync_clock_out_oe == !$past(clkoe_n_s))
    else $error("output clock enable wrong");

  chk_ch1_tristate: assert property (@(posedge core_clk) disable iff (!reset_n)
    oe1_n_s |=> !ch1_sample_oe)
    else $error("channel 1 driven while its enable is high");

  chk_ch0_tristate: assert property (@(posedge core_clk) disable iff (!reset_n)
    !oe0_s |=> !ch0_sample_oe)
    else $error("channel 0 driven while its enable is low");

  chk_sleep_both_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    pop && slp_s == SLEEP_BOTH |=> smp_q[0] == '0 && smp_q[1] == '0)
    else $error("sleeping channels produced samples");

  chk_pd_wake_time: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(mode_q == MODE_RUN) |-> $past(wake_q) == WAKE_PD_CYC - 1'b1)
    else $error("power-down wake time wrong");

  chk_sleep_wake_time: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(ch_rdy[0]) |-> $past(chw_q[0]) == WAKE_SLEEP_CYC - 1'b1 && $past(conv_rise))
    else $error("sleep wake time wrong");

  chk_format_msb: assert property (@(posedge core_clk) disable iff (!reset_n)
    pop && ch_ok[0] && !pd |=> smp_q[0][SAMPLE_W-1] == ($past(word[SAMPLE_W-1]) ^ $past(fmt_s)))
    else $error("sample format msb wrong");

  chk_overrange_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
    pop && ch_ok[1] && !pd |=> ch1_overrange_flag == $past(word[WORD_W-1]))
    else $error("overrange flag wrong");

  chk_update_cause: assert property (@(posedge core_clk) disable iff (!reset_n)
    $changed(smp_q[0]) |-> $past(pop) || $past(pd))
    else $error("sample changed outside a conversion edge");

  chk_bias_off: assert property (@(posedge core_clk) disable iff (!reset_n)
    bias_s == CM_BIAS_OFF |=> !cm_buffer_on)
    else $error("common-mode buffer on with code 00");
endmodule : dao_top
`default_nettype wire

/* hw/dao_pkg.sv */
`default_nettype none
// ==========================================
// shared constants of the output and mode block
package dao_pkg;
  // ==========================================
  // sample path
  localparam int unsigned SAMPLE_W = 10;
  localparam int unsigned STAGE_W = 11;
  localparam logic [10:0] STAGE_OFFSET = 11'h200;
  localparam logic [9:0] CODE_MAX = 10'h3ff;
  localparam int unsigned FIFO_DEPTH_DEF = 32;
  localparam logic FMT_OFFSET_BIN = 1'b0;
  localparam logic FMT_TWOS_COMP = 1'b1;
  // ==========================================
  // wake-up times, counted in conversion clock cycles
  localparam int unsigned WAKE_CNT_W = 10;
  localparam logic [9:0] WAKE_PD_CYC = 10'h384;
  localparam int unsigned SLEEP_CNT_W = 5;
  localparam logic [4:0] WAKE_SLEEP_CYC = 5'h14;
  // ==========================================
  // sleep control and bias codes {hi, lo}
  localparam logic [1:0] SLEEP_BOTH = 2'h0;
  localparam logic [1:0] SLEEP_CH0_ONLY = 2'h1;
  localparam logic [1:0] SLEEP_CH1_ONLY = 2'h2;
  localparam logic [1:0] SLEEP_NONE = 2'h3;
  localparam logic [1:0] CM_BIAS_OFF = 2'h0;
  // ==========================================
  // wishbone register map, byte addresses
  localparam int unsigned WB_ADR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_DROPS = 4'h8;
  localparam logic [3:0] REG_LAST = 4'hc;
  localparam int unsigned CTRL_HOLD_BIT = 0;
  localparam logic CTRL_HOLD_RESET = 1'b0;
  localparam int unsigned DROP_W = 16;
  localparam int unsigned SYNC_STAGES = 3;
  // ==========================================
  // chip mode
  typedef enum logic [2:0] {
    MODE_DOWN = 3'b001,
    MODE_WAKE = 3'b010,
    MODE_RUN = 3'b100
  } dao_mode_type;
endpackage : dao_pkg
`default_nettype wire

/* hw/dao_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// three-stage pin synchroniser; a change counts once stages two and three agree
module dao_sync #(
  parameter int unsigned W = 1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  import dao_pkg::*;
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  if (W < 1) begin : g_bad_width
    $error("dao_sync width must be at least one");
  end

  always_comb
  begin
    out_d = (s3_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;
endmodule : dao_sync
`default_nettype wire

/* hw/dao_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// sample fifo with valid/ready on both sides
module dao_fifo #(
  parameter int unsigned WIDTH = 22,
  parameter int unsigned DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  import dao_pkg::*;
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] wr_d;
  logic [AW:0] rd_q;
  logic [AW:0] rd_d;
  logic push;
  logic pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("dao_fifo depth must be a power of two of at least two");
  end

  assign level = wr_q - rd_q;
  assign in_ready = (level != (AW + 1)'(DEPTH));
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid & in_ready & ~clear;
  assign pop = out_valid & out_ready & ~clear;

  always_comb
  begin
    wr_d = wr_q;
    rd_d = rd_q;
    if (clear)
    begin
      wr_d = '0;
      rd_d = '0;
    end
    else
    begin
      if (push)
        wr_d = wr_q + 1'b1;
      if (pop)
        rd_d = rd_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wr_q[AW-1:0]] <= in_data;
  end
endmodule : dao_fifo
`default_nettype wire

/* verification/dao_capture_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// capture logic on the far side of the sample pins
module dao_capture_model
  import dao_pkg::*;
(
  input wire logic sync_clock_out,
  input wire logic sync_clock_out_oe,
  input wire logic [dao_pkg::SAMPLE_W-1:0] ch0_sample,
  input wire logic ch0_sample_oe,
  input wire logic [dao_pkg::SAMPLE_W-1:0] ch1_sample,
  input wire logic ch1_sample_oe,
  output logic [dao_pkg::SAMPLE_W-1:0] ch0_seen,
  output logic [dao_pkg::SAMPLE_W-1:0] ch1_seen,
  output int unsigned n_capture
);
  logic clk_pin;
  logic [dao_pkg::SAMPLE_W-1:0] seen0_q = '0;
  logic [dao_pkg::SAMPLE_W-1:0] seen1_q = '0;
  int unsigned count_q = 0;
  // released clock line sits at its pull-down level
  always_comb clk_pin = sync_clock_out_oe ? sync_clock_out : 1'b0;
  // both words taken on the rising output clock; a released data line reads inverted
  always @(posedge clk_pin)
  begin
    seen0_q <= ch0_sample_oe ? ch0_sample : ~seen0_q;
    seen1_q <= ch1_sample_oe ? ch1_sample : ~seen1_q;
    count_q <= count_q + 1;
  end
  assign ch0_seen = seen0_q;
  assign ch1_seen = seen1_q;
  assign n_capture = count_q;
endmodule : dao_capture_model
`default_nettype wire

/* verification/dao_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
module dao_top_test;
  import dao_pkg::*;
  logic core_clk = 0, reset_n = 0, conv = 0, pd_n = 0, fmt = 0, sck_en_n = 0;
  logic oe0 = 1, oe1_n = 0, slp_hi = 1, slp_lo = 1, cm_hi = 0, cm_lo = 1;
  logic [10:0] st0 = 11'h200, st1 = 11'h200;
  logic [3:0] adr = '0;
  logic [31:0] dat = '0, rd, dat_o;
  logic [3:0] sel = '0;
  logic we = 0, cyc = 0, stb = 0, ack, s0_oe, s1_oe, ov0, ov1, sck, sck_oe, cm_on;
  logic [9:0] s0, s1, seen0, seen1;
  logic [1:0] cm;
  int unsigned n_cap, n_mismatch = 0, n_checks = 0, cycles = 0, c0, c1, k;
  dao_top #(.FIFO_DEPTH(32)) DUT (.core_clk(core_clk), .reset_n(reset_n),
    .conversion_clock(conv), .chip_powerdown_n(pd_n), .sample_format_select(fmt),
    .sync_clock_out_enable_n(sck_en_n), .ch0_output_enable(oe0),
    .ch1_output_enable_n(oe1_n), .sleep_ctrl_hi(slp_hi), .sleep_ctrl_lo(slp_lo),
    .cm_buffer_bias_hi(cm_hi), .cm_buffer_bias_lo(cm_lo), .ch0_stage_code(st0),
    .ch1_stage_code(st1), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack), .ch0_sample(s0),
    .ch0_sample_oe(s0_oe), .ch0_overrange_flag(ov0), .ch1_sample(s1),
    .ch1_sample_oe(s1_oe), .ch1_overrange_flag(ov1), .sync_clock_out(sck),
    .sync_clock_out_oe(sck_oe), .cm_buffer_bias(cm), .cm_buffer_on(cm_on));
  dao_capture_model partner (.sync_clock_out(sck), .sync_clock_out_oe(sck_oe),
    .ch0_sample(s0), .ch0_sample_oe(s0_oe), .ch1_sample(s1), .ch1_sample_oe(s1_oe),
    .ch0_seen(seen0), .ch1_seen(seen1), .n_capture(n_cap));
  always #5 core_clk = ~core_clk;
  initial
  begin
    #3;
    forever #62.5 conv = ~conv;
  end
  // ==========================================
  // reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles > 70000)
    begin
      n_mismatch++;
      test_done;
    end
  end
  // ==========================================
  // wishbone classic cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    @(posedge core_clk);
    while (ack !== 1'b1)
      @(posedge core_clk);
    rd = dat_o;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge core_clk);
  endtask : wb
  task automatic conv_wait(input int n);
    repeat (n * 25 / 2 + 8) @(posedge core_clk);
  endtask : conv_wait
  // corrected word {overrange, code} as seen at the pins
  function automatic logic [10:0] expect_word(input logic [10:0] st, input logic f);
    logic [9:0] c;
    logic o;
    o = (st < 11'h200) || (st > 11'h5ff);
    c = (st < 11'h200) ? 10'h000 : (st > 11'h5ff) ? CODE_MAX : 10'(st - STAGE_OFFSET);
    if (f == FMT_TWOS_COMP)
      c[9] = ~c[9];
    return {o, c};
  endfunction : expect_word
  task automatic powerup;
    pd_n <= 0;
    conv_wait(4);
    wb(0, REG_STATUS, 0);
    check(rd[6:4], 3'b001);
    check({s0, ov0, s1, ov1, sck, cm}, '0);
    pd_n <= 1;
    conv_wait(800);
    wb(0, REG_STATUS, 0);
    check(rd[6:4], 3'b010);
    conv_wait(105);
    wb(0, REG_STATUS, 0);
    check(rd[6:4], 3'b100);
  endtask : powerup
  initial
  begin
    void'($urandom(63));
    repeat (12) @(posedge core_clk);
    reset_n <= 1;
    powerup;
    wb(0, 4'h2, 0);
    check(rd, 0);
    wb(1, REG_CTRL, 32'h1);
    wb(0, REG_CTRL, 0);
    check(rd[0], 1);
    wb(1, REG_CTRL, 32'h0);
    // ==========================================
    // sample coding, corners then random
    for (k = 0; k < 24; k++)
    begin
      @(posedge core_clk);
      fmt <= k[0];
      st0 <= (k < 4) ? 11'h1ff + 11'(k * 11'h200) : 11'($urandom_range(0, 11'h7ff));
      st1 <= (k < 4) ? 11'h600 - 11'(k) : 11'($urandom_range(0, 11'h7ff));
      conv_wait(4);
      check({ov0, s0}, expect_word(st0, fmt));
      check({ov1, s1}, expect_word(st1, fmt));
      check({seen0, seen1}, {10'(expect_word(st0, fmt)), 10'(expect_word(st1, fmt))});
    end
    wb(0, REG_LAST, 0);
    check(rd[21:0], {expect_word(st1, 0), expect_word(st0, 0)});
    // ==========================================
    // sleep codes and wake time
    {slp_hi, slp_lo} <= SLEEP_CH1_ONLY;
    conv_wait(4);
    check({s0, ov0}, 0);
    check({ov1, s1}, expect_word(st1, fmt));
    {slp_hi, slp_lo} <= SLEEP_BOTH;
    conv_wait(4);
    wb(0, REG_STATUS, 0);
    check({rd[3], rd[2:1], s0, s1}, {1'b1, 22'h0});
    {slp_hi, slp_lo} <= SLEEP_NONE;
    conv_wait(12);
    wb(0, REG_STATUS, 0);
    check(rd[2:1], 0);
    conv_wait(12);
    wb(0, REG_STATUS, 0);
    check(rd[3:1], 3'b011);
    // ==========================================
    // bias codes, enables
    for (k = 0; k < 4; k++)
    begin
      {cm_hi, cm_lo} <= k[1:0];
      conv_wait(1);
      check({cm, cm_on}, {k[1:0], k[1:0] != CM_BIAS_OFF});
    end
    for (k = 0; k < 8; k++)
    begin
      {oe0, oe1_n, sck_en_n} <= k[2:0];
      conv_wait(1);
      c0 = n_cap;
      conv_wait(3);
      check({s0_oe, s1_oe, sck_oe}, {k[2], ~k[1], ~k[0]});
      check(n_cap != c0, !k[0]);
    end
    // ==========================================
    // fifo filled while held, then cleared by power-down
    wb(1, REG_CTRL, 32'h1);
    conv_wait(40);
    wb(0, REG_STATUS, 0);
    check(rd[15:8], 8'd32);
    wb(0, REG_DROPS, 0);
    c1 = rd[15:0];
    check(c1 != 0, 1);
    wb(1, REG_CTRL, 32'h0);
    powerup;
    wb(0, REG_STATUS, 0);
    check(rd[15:8] <= 1, 1);
    test_done;
  end
endmodule : dao_top_test
`default_nettype wire
